// ---- clock_config_pkg.sv ----
// Package of constants for the system clock configuration unit.
package clock_config_pkg;
    // ------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------
    localparam int CFG_W = 8;
    localparam int BIT_SELF_RESET = 7;
    localparam int BIT_PLL_ENABLE = 6;
    localparam int BIT_OSC_ENABLE = 5;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 3;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ------------------------------------------------------------
    // Source select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_FAST_RC = 3'h0;
    localparam logic [2:0] SEL_SLOW_RC = 3'h1;
    localparam logic [2:0] SEL_OSC = 3'h2;
    localparam logic [2:0] SEL_PLL1 = 3'h3;
    // ------------------------------------------------------------
    // Oscillator drive modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_EXT_IN = 2'h0;
    localparam logic [1:0] MODE_XTAL_LOW = 2'h1;
    localparam logic [1:0] MODE_XTAL_MID = 2'h2;
    localparam logic [1:0] MODE_XTAL_HIGH = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int SWITCH_DELAY_US = 75;
    localparam int SWITCH_CYCLES = SWITCH_DELAY_US * CLK_MHZ;
    localparam int PLL_MULT = 16;
    localparam int CNT_W = 16;
endpackage

// ---- clock_switch_glitchless.sv ----
// Glitch-free switch among eight clock enable streams.
`timescale 1ns/1ps
`default_nettype none
module clock_switch_glitchless (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request and sources
    input wire logic [7:0] next_sel,
    input wire logic [7:0] src_tick,
    // Result
    output logic [7:0] cur_sel,
    output logic tick
);
    // ------------------------------------------------------------
    // Selection changes only on a boundary where no pulse leaves.
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_sel <= 8'h01;
        end else if (next_sel != cur_sel && !tick) begin
            cur_sel <= next_sel;
        end
    end

    assign tick = |(src_tick & cur_sel) && (next_sel == cur_sel);
endmodule // clock_switch_glitchless
`default_nettype wire

// ---- osc_source_model.sv ----
// External clock source model feeding the oscillator input pin.
`timescale 1ns/1ps
`default_nettype none
module osc_source_model (
    // Control from the device
    input wire logic enable,
    // Pin level
    output logic osc_out
);
    // A stopped oscillator holds its pin low.
    // The 3 ns offset keeps its edges away from the system clock edges.
    initial begin
        osc_out = 1'b0;
        #3;
        forever begin
            #40;
            osc_out = enable ? ~osc_out : 1'b0;
        end
    end
endmodule // osc_source_model
`default_nettype wire

// ---- system_clock_config.sv ----
// System clock configuration register, source mux and reboot logic.
//
// Functional notes
// R1: One source drives system clock, register-chosen.
// R2: Each write stalls clock roughly 75 us.
// R3: Writing bit 7 reboots chip like reset.
// R4: Software keeps bit 7 zero normally.
// R5: Bit 6 enables or disables the PLL.
// R6: PLL multiplies oscillator input by sixteen; the model's taps count CLK steps, not the oscillator input.
// R7: PLL valid only with oscillator enabled too.
// R8: Software waits 100 us before PLL select.
// R9: Bit 5 enables or disables the oscillator.
// R10: Software waits 10 ms for crystal.
// R11: PLL and oscillator may enable together.
// R12: Settled sources switch by select field only.
// R13: Bits 4:3 choose oscillator drive mode.
// R14: Bits 2:0 choose master clock source.
// R15: Software selects sources only when enabled.
// R16: Software stores mode and frequency copies.
// R17: Software prefers the clock set command.
// R18: Delay is cycle count; switching runt-free.
`timescale 1ns/1ps
`default_nettype none
module system_clock_config
    import clock_config_pkg::*;
#(
    parameter int SWITCH_DELAY = clock_config_pkg::SWITCH_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register write port from the processor
    input wire logic CFG_WE,
    input wire logic [clock_config_pkg::CFG_W-1:0] CFG_WDATA,
    output logic [clock_config_pkg::CFG_W-1:0] CFG_RDATA,
    // Clock source ticks
    input wire logic FAST_RC_TICK,
    input wire logic SLOW_RC_TICK,
    input wire logic OSC_IN_PIN,
    // Oscillator and PLL controls
    output logic OSC_ENABLE,
    output logic [1:0] OSC_DRIVE_MODE,
    output logic PLL_ENABLE,
    output logic PLL_RUN,
    // System clock and status
    output logic SYS_CLK_EN,
    output logic SWITCH_BUSY,
    output logic CHIP_RESET
);
    import clock_config_pkg::*;

    // ------------------------------------------------------------
    // Registers and synchroniser
    // ------------------------------------------------------------
    logic [7:0] cfg;
    logic [CNT_W-1:0] stall;
    logic osc_meta, osc_sync, osc_prev;
    logic osc_tick;
    logic [3:0] pll_phase;
    logic pll_tick;
    logic [7:0] src_tick, next_sel, cur_sel;
    logic mux_tick;

    function automatic logic [7:0] onehot_sel(input logic [2:0] s);
        onehot_sel = 8'h01 << s;
    endfunction

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg <= CFG_RESET;
        end else if (CFG_WE && CFG_WDATA[BIT_SELF_RESET]) begin
            // A reboot leaves the register as a hardware reset would.
            cfg <= CFG_RESET; // [R3]
        end else if (CFG_WE) begin
            cfg <= {1'b0, CFG_WDATA[6:0]}; // [R5] [R9] [R13] [R14]
        end
    end

    // A write of bit 7 pulses the chip reset; the bit itself never
    // lingers, so the reset cannot latch on.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            CHIP_RESET <= 1'b0;
        end else begin
            CHIP_RESET <= CFG_WE && CFG_WDATA[BIT_SELF_RESET]; // [R3]
        end
    end

    // ------------------------------------------------------------
    // Transition delay
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            stall <= '0;
        end else if (CFG_WE) begin
            stall <= CNT_W'(SWITCH_DELAY); // [R2] [R18]
        end else if (stall != '0) begin
            stall <= stall - CNT_W'(1);
        end
    end
    assign SWITCH_BUSY = (stall != '0);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= OSC_IN_PIN;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end
    // The synchronised oscillator edge is gated by its enable before the source mux sees it.
    assign osc_tick = osc_sync && !osc_prev && cfg[BIT_OSC_ENABLE]; // [R9]

    // ------------------------------------------------------------
    // PLL model: sixteen equal-phase ticks per input period is beyond
    // a fabric clock; here the PLL is a phase counter whose divided
    // taps stand in for the times one to sixteen outputs.
    // ------------------------------------------------------------
    assign PLL_RUN = cfg[BIT_PLL_ENABLE] && cfg[BIT_OSC_ENABLE]; // [R7]
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pll_phase <= 4'h0;
        end else if (!PLL_RUN) begin
            pll_phase <= 4'h0;
        end else begin
            pll_phase <= pll_phase + 4'h1; // [R6]
        end
    end
    assign pll_tick = PLL_RUN;

    generate
        for (genvar i = 0; i < 5; i++) begin : g_pll_tap
            // Tap i ticks once every 2**(4-i) PLL steps.
            assign src_tick[3+i] = pll_tick &&
                ((pll_phase & 4'((16 >> i) - 1)) == 4'h0); // [R6] [R14]
        end
    endgenerate
    assign src_tick[0] = FAST_RC_TICK;
    assign src_tick[1] = SLOW_RC_TICK;
    assign src_tick[2] = osc_tick;

    // Selection waits out the stall so sources change with no runt.
    assign next_sel = SWITCH_BUSY ? cur_sel : onehot_sel(cfg[SEL_HI:SEL_LO]);

    clock_switch_glitchless u_switch (
        .clk(CLK),
        .resetn(RESETN),
        .next_sel(next_sel),
        .src_tick(src_tick),
        .cur_sel(cur_sel),
        .tick(mux_tick)
    ); // [R1] [R12] [R18]

    assign SYS_CLK_EN = mux_tick && !SWITCH_BUSY; // [R2]
    assign CFG_RDATA = cfg;
    assign OSC_ENABLE = cfg[BIT_OSC_ENABLE];
    assign OSC_DRIVE_MODE = cfg[MODE_HI:MODE_LO]; // [R13]
    assign PLL_ENABLE = cfg[BIT_PLL_ENABLE]; // [R5]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_write;
        CFG_WE && !CFG_WDATA[BIT_SELF_RESET];
    endsequence
    sequence s_reboot;
        CFG_WE && CFG_WDATA[BIT_SELF_RESET];
    endsequence

    chk_reset_pulse: assert property ( // [R3]
        @(posedge CLK) disable iff (!RESETN)
        s_reboot |=> CHIP_RESET)
        else $error("reboot write did not pulse reset");
    chk_reboot_clear: assert property ( // [R3]
        @(posedge CLK) disable iff (!RESETN)
        s_reboot |=> CFG_RDATA == CFG_RESET)
        else $error("reboot write left the register set");
    chk_bit7_clear: assert property ( // [R3]
        @(posedge CLK) disable iff (!RESETN)
        !cfg[BIT_SELF_RESET])
        else $error("bit 7 stuck in register");
    chk_stall_start: assert property ( // [R2]
        @(posedge CLK) disable iff (!RESETN)
        CFG_WE |=> SWITCH_BUSY [*8])
        else $error("write did not stall clock");
    chk_no_clk_stall: assert property ( // [R2]
        @(posedge CLK) disable iff (!RESETN)
        SWITCH_BUSY |-> !SYS_CLK_EN)
        else $error("clock ran during transition");
    chk_pll_gate: assert property ( // [R7]
        @(posedge CLK) disable iff (!RESETN)
        !PLL_RUN |-> (src_tick[7:3] == 5'h00))
        else $error("pll tap ticked without both enables");
    chk_pll_enable: assert property ( // [R5]
        @(posedge CLK) disable iff (!RESETN)
        s_write |=> PLL_ENABLE == $past(CFG_WDATA[BIT_PLL_ENABLE]))
        else $error("pll enable not following write");
    chk_osc_gate: assert property ( // [R9]
        @(posedge CLK) disable iff (!RESETN)
        !OSC_ENABLE && cur_sel[SEL_OSC] |-> !SYS_CLK_EN)
        else $error("oscillator passed while disabled");
    chk_mode_field: assert property ( // [R13]
        @(posedge CLK) disable iff (!RESETN)
        s_write |=> OSC_DRIVE_MODE == $past(CFG_WDATA[MODE_HI:MODE_LO]))
        else $error("drive mode not following write");
    chk_sel_onehot: assert property ( // [R1]
        @(posedge CLK) disable iff (!RESETN)
        $onehot(cur_sel))
        else $error("more than one source selected");
endmodule // system_clock_config
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the system clock configuration unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clock_config_pkg::*;
    localparam int DLY = 8;
    // The model crystal is steady at once, so only the PLL's 100 us is
    // waited out; a 10 ms crystal wait would outrun the cycle budget.
    localparam int SETTLE = 100 * CLK_MHZ;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic we = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic fast_tick = 1'b0;
    logic slow_tick = 1'b0;
    wire osc_pin;
    logic [7:0] rdata;
    logic osc_en, pll_en, pll_run, sys_en, busy, chip_rst;
    logic [1:0] mode;
    int failures = 0;
    int num_checks = 0;
    int model_cfg = 0;
    int n;
    int e;
    // ------------------------------------------------------------
    // Clock, sources and instances
    // ------------------------------------------------------------
    always #10 clk = ~clk;
    always @(negedge clk) begin
        fast_tick <= 1'($urandom % 2);
        slow_tick <= (($urandom % 4) == 0);
    end
    system_clock_config #(.SWITCH_DELAY(DLY)) uut (.CLK(clk),
        .RESETN(resetn), .CFG_WE(we), .CFG_WDATA(wdata),
        .CFG_RDATA(rdata), .FAST_RC_TICK(fast_tick),
        .SLOW_RC_TICK(slow_tick), .OSC_IN_PIN(osc_pin),
        .OSC_ENABLE(osc_en), .OSC_DRIVE_MODE(mode),
        .PLL_ENABLE(pll_en), .PLL_RUN(pll_run), .SYS_CLK_EN(sys_en),
        .SWITCH_BUSY(busy), .CHIP_RESET(chip_rst));
    osc_source_model xtal (.enable(osc_en), .osc_out(osc_pin));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // This task stands for the clock set command and keeps the mode copy.
    task automatic write_cfg(input logic [7:0] d);
        @(negedge clk);
        we = 1'b1;
        wdata = d;
        @(negedge clk);
        we = 1'b0;
        model_cfg = d[7] ? int'(CFG_RESET) : int'(d & 8'h7f);
    endtask
    // The stall is timed from the last write, so busy must fall exactly.
    task automatic check_fields;
        check(rdata, model_cfg[7:0]);
        check(pll_en, model_cfg[6]);
        check(osc_en, model_cfg[5]);
        check(mode, model_cfg[4:3]);
        check(pll_run, model_cfg[6] & model_cfg[5]);
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            check(sys_en, 1'b0);
            n++;
            @(negedge clk);
        end
        check(n, DLY);
    endtask
    // PLL taps are counter steps, so a 32-cycle window counts exactly.
    task automatic measure(input int sel);
        repeat (20) @(negedge clk);
        n = 0;
        e = 0;
        repeat (32) begin
            @(negedge clk);
            n += int'(sys_en);
            if (sel == 0)
                e += int'(fast_tick);
            else if (sel == 1)
                e += int'(slow_tick);
        end
        if (sel == 2)
            e = 8;
        else if (sel > 2)
            e = 32 >> (7 - sel);
        check(n, e);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n = $urandom(26);
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        check(rdata, CFG_RESET);
        write_cfg(8'h60);
        check_fields;
        repeat (SETTLE) @(negedge clk);
        for (int s = 0; s < 8; s++) begin
            write_cfg(8'h60 | 8'(($urandom % 4) << 3) | 8'(s));
            check_fields;
            measure(s);
        end
        write_cfg(8'h21);
        write_cfg(8'h18);
        check_fields;
        write_cfg(8'he2);
        check(chip_rst, 1'b1);
        check(rdata, model_cfg[7:0]);
        @(negedge clk);
        check(chip_rst, 1'b0);
        check(rdata, CFG_RESET);
        write_cfg(8'h62);
        resetn = 1'b0;
        @(negedge clk);
        check(busy, 1'b0);
        check(rdata, CFG_RESET);
        @(negedge clk);
        resetn = 1'b1;
        check(chip_rst, 1'b0);
        measure(0);
        tally_and_finish;
    end
    initial begin
        #200us;
        failures++;
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
